// *** src/gpx_defines.svh ***
`ifndef GPX_DEFINES_SVH
`define GPX_DEFINES_SVH
// -----------------------------------------------------------
// Register selector codes, low three bits of the command byte
// -----------------------------------------------------------
`define GPX_SEL_IN0 3'h0
`define GPX_SEL_IN1 3'h1
`define GPX_SEL_DRIVE0 3'h2
`define GPX_SEL_DRIVE1 3'h3
`define GPX_SEL_INVERT0 3'h4
`define GPX_SEL_INVERT1 3'h5
`define GPX_SEL_DIR0 3'h6
`define GPX_SEL_DIR1 3'h7
// Register group, selector bits 2:1; bit 0 picks the port
`define GPX_GRP_IN 2'h0
`define GPX_GRP_DRIVE 2'h1
`define GPX_GRP_INVERT 2'h2
`define GPX_GRP_DIR 2'h3
// Reset values
`define GPX_DRIVE_RST 8'hff
`define GPX_INVERT_RST 8'h00
`define GPX_DIR_RST 8'hff
// Fixed upper slave address bits, value arbitrary
`define GPX_ADDR_BASE 5'h1d
// Bits in one serial byte
`define GPX_BYTE_BITS 4'h8
`endif

// *** src/gpx_pkg.sv ***
package gpx_pkg;
    // -------------------------------------------------------
    // Serial slave states, one-hot
    // -------------------------------------------------------
    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_ADDR = 9'h002,
        ST_ADDR_ACK = 9'h004,
        ST_CMD = 9'h008,
        ST_CMD_ACK = 9'h010,
        ST_WDATA = 9'h020,
        ST_WDATA_ACK = 9'h040,
        ST_RDATA = 9'h080,
        ST_RDATA_ACK = 9'h100
    } gpx_state_e;

    // Whole state of the expander core
    typedef struct packed {
        gpx_state_e state;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic [2:0] ptr;
        logic rw;
        logic ack_ok;
        logic sda_oe;
        logic scl_q;
        logic sda_q;
        logic [1:0] capture;
        logic [1:0][7:0] drive;
        logic [1:0][7:0] invert;
        logic [1:0][7:0] dir;
    } gpx_core_s;

    // Whole state of one 8-bit port
    typedef struct packed {
        logic [7:0] snap;
        logic armed;
        logic irq;
    } gpx_port_s;
endpackage

// *** src/gpx_sync2.sv ***
`timescale 1ns/1ps
// -----------------------------------------------------------
// Two-stage synchroniser
// -----------------------------------------------------------
module gpx_sync2 #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // Data
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    typedef struct packed {
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s1;
    } gpx_sync_s;

    gpx_sync_s cur_r;
    gpx_sync_s cur_nxt;

    // First stage feeds only the second
    always_comb begin
        cur_nxt.s1 = d_i;
        cur_nxt.s2 = cur_r.s1;
    end

    // Stage registers
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            cur_r <= '0;
        end else begin
            cur_r <= cur_nxt;
        end
    end

    assign q_o = cur_r.s2;
endmodule

// *** src/gpx_port.sv ***
`timescale 1ns/1ps
// -----------------------------------------------------------
// One 8-bit port: pin drivers, read value, change detect
// -----------------------------------------------------------
module gpx_port (
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // Synchronised pin levels and settings
    input wire logic [7:0] level_i,
    input wire logic [7:0] dir_i,
    input wire logic [7:0] drive_i,
    input wire logic [7:0] invert_i,
    input wire logic capture_i,
    // Pin drivers
    output logic [7:0] pin_o,
    output logic [7:0] pin_oe_o,
    // Read value and change flag
    output logic [7:0] read_o,
    output logic irq_o
);
    gpx_pkg::gpx_port_s cur_r;
    gpx_pkg::gpx_port_s cur_nxt;
    logic [7:0] diff;

    // Only input-mode pins can flag a change
    assign diff = (level_i ^ cur_r.snap) & dir_i; // RQ21 RQ22

    // Snapshot after reset and on each read of its input register; flag tracks diff
    always_comb begin
        cur_nxt = cur_r;
        cur_nxt.armed = 1'b1;
        if (!cur_r.armed || capture_i) begin
            cur_nxt.snap = level_i; // RQ20
        end
        // Clears when pins return or on a read of its input register
        cur_nxt.irq = cur_r.armed && !capture_i && (|diff); // RQ17 RQ18
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            cur_r <= '0;
        end else begin
            cur_r <= cur_nxt;
        end
    end

    // Push-pull drive only when configured as output
    assign pin_o = drive_i; // RQ13
    assign pin_oe_o = ~dir_i; // RQ12
    assign read_o = level_i ^ invert_i; // RQ7 RQ11
    assign irq_o = cur_r.irq;

    property p_irq_set;
        @(posedge clock_i) disable iff (reset_i)
        (cur_r.armed && !capture_i && (|diff)) |=> cur_r.irq;
    endproperty
    a_irq_set: assert property (p_irq_set) // RQ17
        else $error("input change did not raise flag");

    property p_irq_idle;
        @(posedge clock_i) disable iff (reset_i)
        !(|((level_i ^ cur_r.snap) & dir_i)) |=> !cur_r.irq;
    endproperty
    a_irq_idle: assert property (p_irq_idle) // RQ18
        else $error("flag set without input change");

    property p_capture;
        @(posedge clock_i) disable iff (reset_i)
        capture_i |=> (!cur_r.irq && cur_r.snap == $past(level_i));
    endproperty
    a_capture: assert property (p_capture) // RQ19
        else $error("read did not clear flag or snapshot");
endmodule

// *** src/gpx_expander.sv ***
`timescale 1ns/1ps
`include "gpx_defines.svh"
// -----------------------------------------------------------
// Summary of operation
// RQ1: Two strap pins form low slave address bits, four addresses.
// RQ2: Address byte bit 0 high reads, low writes.
// RQ3: First byte after write address goes to the pointer.
// RQ4: Pointer low three bits pick one of eight registers.
// RQ5: Pointer itself is never readable.
// RQ6: Codes 0-7: input, drive, invert, direction pairs.
// RQ7: Input registers show pin levels in either direction.
// RQ8: Writes to input registers are dropped silently.
// RQ9: Drive bits act on outputs only, reset to ones.
// RQ10: Drive register reads return last written value.
// RQ11: Invert bit one flips read level; resets zero.
// RQ12: Direction one is input, zero output; resets ones.
// RQ13: Output pins driven high or low from drive bit.
// RQ14: Power-on reset restores registers and bus state.
// RQ15: Reset pin low forces full reset at any time.
// RQ16: Master holds reset pin low long enough.
// RQ17: Any input-mode pin edge raises interrupt.
// RQ18: Interrupt drops on return to old value or read.
// RQ19: Read clears interrupt at the acknowledge clock rise.
// RQ20: Changes after clearing signal again.
// RQ21: Output-mode pins never interrupt.
// RQ22: Switching output to input may raise interrupt.
// RQ23: Master starts only on an idle bus.
// RQ24: After each data byte move to pair partner.
// RQ25: Master withholds ack on the last read byte.
// RQ26: Interrupt is open drain, low while pending.
// RQ27: Pin levels synchronised before use.
// -----------------------------------------------------------
module gpx_expander #(
    parameter logic [4:0] ADDR_BASE = `GPX_ADDR_BASE
) (
    // Clock and power-on reset
    input wire logic clock_i,
    input wire logic reset_i,
    // Reset pin, active low
    input wire logic reset_pin_n_i,
    // Address straps
    input wire logic addr_sel_lo_i,
    input wire logic addr_sel_hi_i,
    // Serial bus
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // Interrupt, open drain
    output logic int_n_o,
    output logic int_n_oe_o,
    // Port pins, port 1 in the upper byte
    input wire logic [15:0] port_pin_i,
    output logic [15:0] port_pin_o,
    output logic [15:0] port_pin_oe_o
);
    gpx_pkg::gpx_core_s cur_r;
    gpx_pkg::gpx_core_s cur_nxt;
    logic rst_pin_sync;
    logic core_rst;
    logic [19:0] sync_q;
    logic scl_s;
    logic sda_s;
    logic [6:0] my_addr;
    logic start_det;
    logic stop_det;
    logic scl_rise;
    logic scl_fall;
    logic evt_fall;
    logic byte_done;
    logic [1:0][7:0] port_rd;
    logic [1:0] port_irq;
    logic [7:0] rd_byte;

    // -------------------------------------------------------
    // Register read mux
    // -------------------------------------------------------
    // No pointer case exists, so the pointer has no read path
    function automatic logic [7:0] rd_sel(
        input logic [2:0] sel,
        input logic [1:0][7:0] lvl,
        input logic [1:0][7:0] drv,
        input logic [1:0][7:0] inv,
        input logic [1:0][7:0] dir
    );
        logic [7:0] r;
        case (sel[2:1]) // RQ4 RQ5 RQ6
            `GPX_GRP_IN: r = lvl[sel[0]];
            `GPX_GRP_DRIVE: r = drv[sel[0]]; // RQ10
            `GPX_GRP_INVERT: r = inv[sel[0]];
            default: r = dir[sel[0]];
        endcase
        return r;
    endfunction

    // -------------------------------------------------------
    // Reset and input synchronisation
    // -------------------------------------------------------
    // Pin reset asserts at once, releases through two stages
    gpx_sync2 #(
        .WIDTH(1)
    ) u_rst_sync (
        .clock_i(clock_i),
        .reset_i(reset_i | ~reset_pin_n_i), // RQ15
        .d_i(1'b1),
        .q_o(rst_pin_sync)
    );

    assign core_rst = reset_i | ~rst_pin_sync; // RQ14 RQ15

    // Two stages per pin; runs through a pin reset for a true snapshot
    gpx_sync2 #(
        .WIDTH(20)
    ) u_pin_sync (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .d_i({addr_sel_hi_i, addr_sel_lo_i, sda_i, scl_i, port_pin_i}),
        .q_o(sync_q)
    ); // RQ27

    assign scl_s = sync_q[16];
    assign sda_s = sync_q[17];
    assign my_addr = {ADDR_BASE, sync_q[19], sync_q[18]}; // RQ1

    // -------------------------------------------------------
    // Bus condition detection
    // -------------------------------------------------------
    // Start and stop are data edges while the clock is high
    assign start_det = scl_s && cur_r.scl_q && cur_r.sda_q && !sda_s;
    assign stop_det = scl_s && cur_r.scl_q && !cur_r.sda_q && sda_s;
    assign scl_rise = scl_s && !cur_r.scl_q;
    assign scl_fall = !scl_s && cur_r.scl_q;
    assign evt_fall = scl_fall && !start_det && !stop_det;
    assign byte_done = cur_r.bit_cnt == `GPX_BYTE_BITS;

    assign rd_byte = rd_sel(cur_r.ptr, port_rd, cur_r.drive,
                            cur_r.invert, cur_r.dir);

    // -------------------------------------------------------
    // Serial slave and register file
    // -------------------------------------------------------
    // Samples data on clock rise, changes data on clock fall
    always_comb begin
        cur_nxt = cur_r;
        cur_nxt.scl_q = scl_s;
        cur_nxt.sda_q = sda_s;
        cur_nxt.capture = 2'b00;
        if (start_det) begin
            // Repeated start aborts any byte in flight
            cur_nxt.state = gpx_pkg::ST_ADDR;
            cur_nxt.bit_cnt = 4'h0;
            cur_nxt.sda_oe = 1'b0;
        end else if (stop_det) begin
            cur_nxt.state = gpx_pkg::ST_IDLE;
            cur_nxt.sda_oe = 1'b0;
        end else if (scl_rise) begin
            case (cur_r.state)
                gpx_pkg::ST_ADDR,
                gpx_pkg::ST_CMD,
                gpx_pkg::ST_WDATA: begin
                    cur_nxt.shift = {cur_r.shift[6:0], sda_s};
                    cur_nxt.bit_cnt = cur_r.bit_cnt + 4'h1;
                end
                gpx_pkg::ST_RDATA: begin
                    cur_nxt.bit_cnt = cur_r.bit_cnt + 4'h1;
                end
                gpx_pkg::ST_RDATA_ACK: begin
                    // Master ack or nack; a read of an input byte
                    // snapshots that port and clears its flag
                    cur_nxt.ack_ok = !sda_s; // RQ25
                    if (cur_r.ptr[2:1] == `GPX_GRP_IN) begin
                        cur_nxt.capture[cur_r.ptr[0]] = 1'b1; // RQ19
                    end
                    cur_nxt.ptr[0] = !cur_r.ptr[0]; // RQ24
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (cur_r.state)
                gpx_pkg::ST_ADDR: begin
                    if (byte_done) begin
                        if (cur_r.shift[7:1] == my_addr) begin // RQ1
                            cur_nxt.state = gpx_pkg::ST_ADDR_ACK;
                            cur_nxt.rw = cur_r.shift[0]; // RQ2
                            cur_nxt.sda_oe = 1'b1;
                        end else begin
                            cur_nxt.state = gpx_pkg::ST_IDLE;
                        end
                    end
                end
                gpx_pkg::ST_CMD: begin
                    if (byte_done) begin
                        cur_nxt.ptr = cur_r.shift[2:0]; // RQ3 RQ4
                        cur_nxt.state = gpx_pkg::ST_CMD_ACK;
                        cur_nxt.sda_oe = 1'b1;
                    end
                end
                gpx_pkg::ST_WDATA: begin
                    if (byte_done) begin
                        case (cur_r.ptr[2:1])
                            `GPX_GRP_DRIVE: begin
                                cur_nxt.drive[cur_r.ptr[0]] = cur_r.shift;
                            end
                            `GPX_GRP_INVERT: begin
                                cur_nxt.invert[cur_r.ptr[0]] = cur_r.shift;
                            end
                            `GPX_GRP_DIR: begin
                                cur_nxt.dir[cur_r.ptr[0]] = cur_r.shift;
                            end
                            default: begin
                                // Input registers ignore data
                            end
                        endcase // RQ8
                        cur_nxt.ptr[0] = !cur_r.ptr[0]; // RQ24
                        cur_nxt.state = gpx_pkg::ST_WDATA_ACK;
                        cur_nxt.sda_oe = 1'b1;
                    end
                end
                gpx_pkg::ST_ADDR_ACK: begin
                    cur_nxt.bit_cnt = 4'h0;
                    if (cur_r.rw) begin
                        // Read: first bit out right away
                        cur_nxt.state = gpx_pkg::ST_RDATA;
                        cur_nxt.shift = rd_byte;
                        cur_nxt.sda_oe = !rd_byte[7];
                    end else begin
                        cur_nxt.state = gpx_pkg::ST_CMD;
                        cur_nxt.sda_oe = 1'b0;
                    end
                end
                gpx_pkg::ST_CMD_ACK,
                gpx_pkg::ST_WDATA_ACK: begin
                    cur_nxt.state = gpx_pkg::ST_WDATA;
                    cur_nxt.bit_cnt = 4'h0;
                    cur_nxt.sda_oe = 1'b0;
                end
                gpx_pkg::ST_RDATA: begin
                    if (byte_done) begin
                        cur_nxt.state = gpx_pkg::ST_RDATA_ACK;
                        cur_nxt.sda_oe = 1'b0;
                    end else begin
                        cur_nxt.sda_oe = !cur_r.shift[6];
                        cur_nxt.shift = {cur_r.shift[6:0], 1'b1};
                    end
                end
                gpx_pkg::ST_RDATA_ACK: begin
                    cur_nxt.bit_cnt = 4'h0;
                    if (cur_r.ack_ok) begin
                        // Pointer already moved to the partner
                        cur_nxt.state = gpx_pkg::ST_RDATA;
                        cur_nxt.shift = rd_byte;
                        cur_nxt.sda_oe = !rd_byte[7];
                    end else begin
                        // Nack ends the read; wait for stop
                        cur_nxt.state = gpx_pkg::ST_IDLE;
                        cur_nxt.sda_oe = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // State register; both reset sources land here
    always_ff @(posedge clock_i or posedge core_rst) begin
        if (core_rst) begin
            cur_r <= '0;
            cur_r.state <= gpx_pkg::ST_IDLE; // RQ14
            cur_r.drive <= {2{`GPX_DRIVE_RST}}; // RQ9
            cur_r.invert <= {2{`GPX_INVERT_RST}}; // RQ11
            cur_r.dir <= {2{`GPX_DIR_RST}}; // RQ12
        end else begin
            cur_r <= cur_nxt;
        end
    end

    // -------------------------------------------------------
    // Ports
    // -------------------------------------------------------
    for (genvar p = 0; p < 2; p++) begin : g_port
        gpx_port u_port (
            .clock_i(clock_i),
            .reset_i(core_rst),
            .level_i(sync_q[8*p +: 8]),
            .dir_i(cur_r.dir[p]),
            .drive_i(cur_r.drive[p]),
            .invert_i(cur_r.invert[p]),
            .capture_i(cur_r.capture[p]),
            .pin_o(port_pin_o[8*p +: 8]),
            .pin_oe_o(port_pin_oe_o[8*p +: 8]),
            .read_o(port_rd[p]),
            .irq_o(port_irq[p])
        );
    end

    // Open-drain outputs only ever pull low
    assign sda_o = 1'b0;
    assign sda_oe_o = cur_r.sda_oe;
    assign int_n_o = 1'b0;
    assign int_n_oe_o = |port_irq; // RQ26

    // -------------------------------------------------------
    // Assertions
    // -------------------------------------------------------
    property p_addr_nack;
        @(posedge clock_i) disable iff (core_rst)
        (cur_r.state == gpx_pkg::ST_ADDR && evt_fall && byte_done
            && cur_r.shift[7:1] != my_addr)
        |=> (cur_r.state == gpx_pkg::ST_IDLE && !cur_r.sda_oe);
    endproperty
    a_addr_nack: assert property (p_addr_nack) // RQ1
        else $error("foreign address was acknowledged");
    property p_read_load;
        @(posedge clock_i) disable iff (core_rst)
        (cur_r.state == gpx_pkg::ST_ADDR_ACK && evt_fall && cur_r.rw)
        |=> (cur_r.state == gpx_pkg::ST_RDATA
            && cur_r.shift == $past(rd_byte));
    endproperty
    a_read_load: assert property (p_read_load) // RQ2
        else $error("read address did not load register data");
    property p_ptr_store;
        @(posedge clock_i) disable iff (core_rst)
        (cur_r.state == gpx_pkg::ST_CMD && evt_fall && byte_done)
        |=> (cur_r.ptr == $past(cur_r.shift[2:0])
            && cur_r.state == gpx_pkg::ST_CMD_ACK);
    endproperty
    a_ptr_store: assert property (p_ptr_store) // RQ3
        else $error("command byte not stored in pointer");
    property p_input_ro;
        @(posedge clock_i) disable iff (core_rst)
        (cur_r.state == gpx_pkg::ST_WDATA && evt_fall && byte_done
            && cur_r.ptr[2:1] == `GPX_GRP_IN)
        |=> ($stable(cur_r.drive) && $stable(cur_r.invert)
            && $stable(cur_r.dir));
    endproperty
    a_input_ro: assert property (p_input_ro) // RQ8
        else $error("write to input register changed state");
    property p_pair_step;
        @(posedge clock_i) disable iff (core_rst)
        (cur_r.state == gpx_pkg::ST_WDATA && evt_fall && byte_done)
        |=> (cur_r.ptr[0] != $past(cur_r.ptr[0])
            && cur_r.ptr[2:1] == $past(cur_r.ptr[2:1]));
    endproperty
    a_pair_step: assert property (p_pair_step) // RQ24
        else $error("pointer did not move to pair partner");
    property p_reset_vals;
        @(posedge clock_i) disable iff (core_rst)
        $fell(core_rst) |-> (port_pin_oe_o == 16'h0000
            && cur_r.drive == {2{`GPX_DRIVE_RST}}
            && cur_r.invert == {2{`GPX_INVERT_RST}}
            && cur_r.state == gpx_pkg::ST_IDLE);
    endproperty
    a_reset_vals: assert property (p_reset_vals) // RQ14
        else $error("state not at defaults after reset");
    property p_drive_pins;
        @(posedge clock_i) disable iff (core_rst)
        (cur_r.state == gpx_pkg::ST_WDATA && evt_fall && byte_done
            && cur_r.ptr == `GPX_SEL_DIR0)
        |=> (port_pin_oe_o[7:0] == ~$past(cur_r.shift));
    endproperty
    a_drive_pins: assert property (p_drive_pins) // RQ13
        else $error("direction write did not steer drivers");
endmodule

// *** testbench/gpx_master.sv ***
`timescale 1ns/1ps
// -----------------------------------------------------------
// Serial bus master model, clock stands high between frames
// -----------------------------------------------------------
module gpx_master (
    // Clock and resolved data wire
    input wire logic clock_i,
    input wire logic sda_i,
    // Bus drivers
    output logic scl_o,
    output logic sda_low_o
);
    // Idle bus: clock high, data released
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    // Start or repeated start, begun on an idle bus or mid-transfer after a byte
    task automatic start();
        tick(4);
        sda_low_o <= 1'b0;
        tick(2);
        scl_o <= 1'b1;
        tick(2);
        sda_low_o <= 1'b1;
        tick(2);
        scl_o <= 1'b0;
    endtask
    task automatic stop();
        tick(2);
        sda_low_o <= 1'b1;
        tick(2);
        scl_o <= 1'b1;
        tick(2);
        sda_low_o <= 1'b0;
        tick(6);
    endtask
    // Data moves mid low phase, sampled mid high phase
    task automatic bit_io(input logic b, output logic r);
        tick(2);
        sda_low_o <= ~b;
        tick(2);
        scl_o <= 1'b1;
        tick(2);
        r = sda_i;
        tick(2);
        scl_o <= 1'b0;
    endtask
    // Byte out MSB first; ack is the sampled ninth bit
    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, ack);
    endtask
    // Byte in; last byte of a read is not acknowledged
    task automatic recv(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(nack, r);
    endtask
endmodule

// *** testbench/gpx_expander_tb.sv ***
`timescale 1ns/1ps
`include "gpx_defines.svh"
// -----------------------------------------------------------
// Expander bench
// -----------------------------------------------------------
module gpx_expander_tb;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic reset_pin_n = 1'b0;
    logic [1:0] strap = 2'b00;
    logic [15:0] ext = 16'h0000;
    logic scl, sda_low, sda, sda_oe, int_oe, sda_val, int_val;
    logic [15:0] pin_o, pin_oe, pins;
    int err_count = 0;
    int num_checks = 0;
    // Pulled-up data wire; pins follow drivers where enabled
    assign sda = ~sda_low & (sda_oe ? sda_val : 1'b1);
    assign pins = (pin_oe & pin_o) | (~pin_oe & ext);
    initial forever #50 clock_i = ~clock_i;
    gpx_master m_u (
        .clock_i(clock_i),
        .sda_i(sda),
        .scl_o(scl),
        .sda_low_o(sda_low)
    );
    gpx_expander dut_u (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .reset_pin_n_i(reset_pin_n),
        .addr_sel_lo_i(strap[0]),
        .addr_sel_hi_i(strap[1]),
        .scl_i(scl),
        .sda_i(sda),
        .sda_o(sda_val),
        .sda_oe_o(sda_oe),
        .int_n_o(int_val),
        .int_n_oe_o(int_oe),
        .port_pin_i(pins),
        .port_pin_o(pin_o),
        .port_pin_oe_o(pin_oe)
    );
    // -------------------------------------------------------
    // Shared tasks
    // -------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Bounded wait for the interrupt line to settle
    task automatic wait_int(input logic lvl);
        num_checks++;
        for (int i = 0; i < 20; i++) begin
            @(posedge clock_i);
            if (int_oe === lvl) return;
        end
        $display("unexpected at %0t: got %h exp %h", $time, int_oe, lvl);
        err_count++;
        summarize();
    endtask
    task automatic wr(input logic [7:0] cmd, d0, d1, input int n);
        logic a;
        m_u.start();
        m_u.send({`GPX_ADDR_BASE, strap, 1'b0}, a);
        chk(16'(a), 16'h0000);
        m_u.send(cmd, a);
        m_u.send(d0, a);
        if (n > 1) m_u.send(d1, a);
        m_u.stop();
    endtask
    // Pointer write, repeated start, two bytes read
    task automatic rd2(input logic [7:0] cmd, output logic [7:0] d0, d1);
        logic a;
        m_u.start();
        m_u.send({`GPX_ADDR_BASE, strap, 1'b0}, a);
        m_u.send(cmd, a);
        m_u.start();
        m_u.send({`GPX_ADDR_BASE, strap, 1'b1}, a);
        m_u.recv(1'b0, d0);
        m_u.recv(1'b1, d1);
        m_u.stop();
    endtask
    // -------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------
    task automatic t_defaults();
        logic [7:0] a, b;
        chk(pin_oe, 16'h0000);
        chk(pin_o, 16'hffff);
        rd2(8'h02, a, b);
        chk({a, b}, 16'hffff);
        rd2(8'h05, a, b);
        chk({a, b}, 16'h0000);
        rd2(8'h07, a, b);
        chk({a, b}, 16'hffff);
    endtask
    // Each strap setting answers its own address and not its complement
    task automatic t_addr();
        logic a;
        for (int s = 0; s < 4; s++) begin
            strap <= 2'(s);
            m_u.tick(4);
            m_u.start();
            m_u.send({`GPX_ADDR_BASE, 2'(s), 1'b0}, a);
            chk(16'(a), 16'h0000);
            m_u.stop();
            m_u.start();
            m_u.send({`GPX_ADDR_BASE, ~2'(s), 1'b0}, a);
            chk(16'(a), 16'h0001);
            m_u.stop();
        end
        strap <= 2'b10;
        m_u.tick(4);
    endtask
    task automatic t_ports();
        logic [7:0] a, b;
        ext <= 16'h3c3c;
        wr(8'h03, 8'h5a, 8'ha5, 2);
        wr(8'h06, 8'h0f, 8'h00, 1);
        chk(pin_oe, 16'h00f0);
        chk(pin_o, 16'h5aa5);
        rd2(8'h00, a, b);
        chk({a, b}, 16'hac3c);
        rd2(8'h02, a, b);
        chk({a, b}, 16'ha55a);
        wr(8'h00, 8'h00, 8'h00, 2);
        wr(8'hfa, 8'h11, 8'h00, 1);
        rd2(8'h02, a, b);
        chk({a, b}, 16'h115a);
        rd2(8'h06, a, b);
        chk({a, b}, 16'h0fff);
        wr(8'h05, 8'hff, 8'h00, 1);
        rd2(8'h01, a, b);
        chk({a, b}, 16'hc31c);
    endtask
    task automatic t_irq();
        logic [7:0] a, b;
        chk(16'(int_oe), 16'h0000);
        ext <= 16'h3d3c;
        wait_int(1'b1);
        chk(16'(int_val), 16'h0000);
        ext <= 16'h3c3c;
        wait_int(1'b0);
        ext <= 16'h7c3c;
        wait_int(1'b1);
        rd2(8'h01, a, b);
        chk(16'(int_oe), 16'h0000);
        ext <= 16'h3c3c;
        wait_int(1'b1);
        rd2(8'h01, a, b);
        wr(8'h02, 8'he1, 8'h00, 1);
        m_u.tick(10);
        chk(16'(int_oe), 16'h0000);
    endtask
    // Reset pin pulsed in mid-transfer
    task automatic t_pin_reset();
        logic [7:0] a, b;
        logic k;
        m_u.start();
        m_u.send({`GPX_ADDR_BASE, strap, 1'b0}, k);
        reset_pin_n <= 1'b0;
        m_u.tick(2);
        chk(pin_oe, 16'h0000);
        reset_pin_n <= 1'b1;
        m_u.stop();
        rd2(8'h02, a, b);
        chk({a, b}, 16'hffff);
        rd2(8'h04, a, b);
        chk({a, b}, 16'h0000);
        chk(16'(int_oe), 16'h0000);
    endtask
    // Main sequence
    initial begin
        repeat (12) @(posedge clock_i);
        reset_i <= 1'b0;
        reset_pin_n <= 1'b1;
        m_u.tick(6);
        t_defaults();
        t_addr();
        t_ports();
        t_irq();
        t_pin_reset();
        summarize();
    end
endmodule
